// *** pkg/seek_feat_pkg.sv ***
package seek_feat_pkg;
	// register byte offsets on the bus
	localparam logic [7:0] OFS_FEATURE = 8'h00;
	localparam logic [7:0] OFS_SECT_COUNT = 8'h04;
	localparam logic [7:0] OFS_SECT_NUM = 8'h08;
	localparam logic [7:0] OFS_CYL_LOW = 8'h0c;
	localparam logic [7:0] OFS_CYL_HIGH = 8'h10;
	localparam logic [7:0] OFS_DEV_HEAD = 8'h14;
	localparam logic [7:0] OFS_COMMAND = 8'h18;
	localparam logic [7:0] OFS_ERROR = 8'h1c;
	localparam logic [7:0] OFS_STATUS = 8'h20;
	localparam logic [7:0] OFS_FEAT_STATE = 8'h24;
	localparam logic [7:0] OFS_APM_LEVEL = 8'h28;
	localparam logic [7:0] OFS_XFER_MODE = 8'h2c;
	localparam logic [7:0] OFS_HOST_TIME = 8'h30;
	// field positions
	localparam int ERR_ABORT_BIT = 2;
	localparam int ST_BUSY_BIT = 7;
	localparam int ST_READY_BIT = 6;
	localparam int ST_SEEK_DONE_BIT = 4;
	localparam int ST_ERR_BIT = 0;
	localparam int DH_LBA_BIT = 6;
	localparam int FS_SERIAL_LSB = 8;
	// command and subfunction codes
	localparam logic [3:0] CMD_SEEK_NIBBLE = 4'h7;
	localparam logic [7:0] CMD_SET_FEATURES = 8'hef;
	localparam logic [7:0] SF_WC_ON = 8'h02;
	localparam logic [7:0] SF_XFER_MODE = 8'h03;
	localparam logic [7:0] SF_APM_ON = 8'h05;
	localparam logic [7:0] SF_PUIS_ON = 8'h06;
	localparam logic [7:0] SF_PUIS_SPINUP = 8'h07;
	localparam logic [7:0] SF_SERIAL_ON = 8'h10;
	localparam logic [7:0] SF_HOST_TIME = 8'h43;
	localparam logic [7:0] SF_EPC = 8'h4a;
	localparam logic [7:0] SF_RLA_OFF = 8'h55;
	localparam logic [7:0] SF_REVERT_OFF = 8'h66;
	localparam logic [7:0] SF_WC_OFF = 8'h82;
	localparam logic [7:0] SF_APM_OFF = 8'h85;
	localparam logic [7:0] SF_PUIS_OFF = 8'h86;
	localparam logic [7:0] SF_SERIAL_OFF = 8'h90;
	localparam logic [7:0] SF_RLA_ON = 8'haa;
	localparam logic [7:0] SF_REVERT_ON = 8'hcc;
	// transfer types (sector count bits 7:3) and highest mode of each
	localparam logic [4:0] XT_PIO_DEFAULT = 5'h00;
	localparam logic [4:0] XT_PIO_FLOW = 5'h01;
	localparam logic [4:0] XT_MW_DMA = 5'h04;
	localparam logic [4:0] XT_ULTRA_DMA = 5'h08;
	localparam logic [2:0] XM_PIO_DEFAULT_MAX = 3'h1;
	localparam logic [2:0] XM_PIO_FLOW_MAX = 3'h4;
	localparam logic [2:0] XM_MW_DMA_MAX = 3'h2;
	localparam logic [2:0] XM_ULTRA_DMA_MAX = 3'h6;
	// advanced power management levels refused
	localparam logic [7:0] APM_BAD_LOW = 8'h00;
	localparam logic [7:0] APM_BAD_HIGH = 8'hff;
	// serial-link feature selectors
	localparam logic [7:0] SER_MAX = 8'h06;
	localparam logic [7:0] SER_HOLE = 8'h05;
	// values after reset
	localparam logic RST_WRITE_CACHE = 1'b1;
	localparam logic RST_READ_AHEAD = 1'b1;
	localparam logic RST_REVERT = 1'b0;
	localparam logic RST_RELEASE_INT = 1'b0;
	localparam logic [7:0] RST_XFER_MODE = 8'h00;
	localparam logic [7:0] RST_STATUS_IDLE = 8'h50;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_EXEC = 2'b01,
		ST_SEEK = 2'b10
	} exec_state_t;
endpackage : seek_feat_pkg

// *** core/seek_feat_cmd.sv ***
// Summary of operation
// - command code 7x starts a seek
// - seek never checks medium format
// - LBA target spread over four registers
// - CHS target: cylinder registers, head low nibble
// - seek end returns position, same mapping
// - EFh is set features; unknown subfunction aborts
// - 02h/82h write cache on/off
// - AAh/55h read look-ahead on/off
// - CCh/66h revert to defaults on/off
// - 05h/85h power management on/off, level
// - 06h/07h/86h standby power-up controls
// - accept 43h host time, 4Ah power conditions
// - reset defaults cache, look-ahead on, others off
// - transfer mode: type bits 7:3, mode 2:0
// - type 0 modes 0 and 1 default PIO
// - type 1 flow-controlled PIO, modes 0-4
// - type 4 DMA 0-2, type 8 ultra 0-6
// - full reassignment forces write cache off
// - serial selectors 01h,02h,03h,04h,06h only
// - power management level 00h/FFh aborts
`timescale 1ns/1ns
module seek_feat_cmd
	import seek_feat_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic reassign_full,
	input wire logic seek_done,
	output logic seek_req,
	output logic seek_lba,
	output logic [27:0] seek_target,
	output logic write_cache_on,
	output logic read_ahead_on
);

	function automatic logic is_seek(input logic [7:0] code);
		is_seek = (code[7:4] == CMD_SEEK_NIBBLE);
	endfunction : is_seek

	function automatic logic xfer_ok(input logic [7:0] sc);
		logic [4:0] kind;
		logic [2:0] mode;
		kind = sc[7:3];
		mode = sc[2:0];
		case (kind)
			XT_PIO_DEFAULT: xfer_ok = (mode <= XM_PIO_DEFAULT_MAX);
			XT_PIO_FLOW: xfer_ok = (mode <= XM_PIO_FLOW_MAX);
			XT_MW_DMA: xfer_ok = (mode <= XM_MW_DMA_MAX);
			XT_ULTRA_DMA: xfer_ok = (mode <= XM_ULTRA_DMA_MAX);
			default: xfer_ok = 1'b0;
		endcase
	endfunction : xfer_ok

	function automatic logic serial_ok(input logic [7:0] sc);
		serial_ok = (sc != 8'h00) && (sc <= SER_MAX) && (sc != SER_HOLE);
	endfunction : serial_ok

	// bus side
	logic wr_pend_q;
	logic [7:0] wr_addr_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic addr_phase;

	// command block
	logic [7:0] feature_q;
	logic [7:0] sect_count_q;
	logic [7:0] sect_num_q;
	logic [7:0] cyl_low_q;
	logic [7:0] cyl_high_q;
	logic [7:0] dev_head_q;
	logic [7:0] command_q;
	logic [7:0] error_q;
	logic seek_end_q;
	logic busy;
	logic cmd_write;

	// feature state
	logic wc_q;
	logic rla_q;
	logic revert_q;
	logic apm_q;
	logic [7:0] apm_level_q;
	logic puis_q;
	logic spinup_q;
	logic [5:0] serial_q;
	logic [7:0] xfer_q;
	logic [31:0] host_time_q;

	exec_state_t state_q;
	exec_state_t state_d;
	logic sf_exec;
	logic sf_abort;
	logic [15:0] feat_state;
	logic [7:0] status;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_q;
	assign addr_phase = hsel && htrans[1] && hready;
	assign busy = (state_q != ST_IDLE);
	// host writes into the command block are dropped while busy, as on a real taskfile
	assign cmd_write = wr_pend_q && !busy;
	assign sf_exec = (state_q == ST_EXEC) && (command_q == CMD_SET_FEATURES);

	assign status = {busy, !busy, 1'b0, seek_end_q, 3'b000, error_q != 8'h00};
	// bit 7 is spare so that the serial features sit in 13:8
	assign feat_state = {reassign_full, 1'b0, serial_q, 1'b0, RST_RELEASE_INT, spinup_q,
		puis_q, apm_q, revert_q, rla_q, wc_q};

	// abort decode for set features
	always_comb begin
		case (feature_q)
			SF_WC_ON, SF_WC_OFF, SF_RLA_ON, SF_RLA_OFF, SF_REVERT_ON, SF_REVERT_OFF,
			SF_APM_OFF, SF_PUIS_ON, SF_PUIS_OFF, SF_PUIS_SPINUP, SF_HOST_TIME,
			SF_EPC: sf_abort = 1'b0;
			SF_XFER_MODE: sf_abort = !xfer_ok(sect_count_q);
			SF_APM_ON: sf_abort = (sect_count_q == APM_BAD_LOW)
				|| (sect_count_q == APM_BAD_HIGH);
			SF_SERIAL_ON, SF_SERIAL_OFF: sf_abort = !serial_ok(sect_count_q);
			default: sf_abort = 1'b1;
		endcase
	end

	// read mux, sampled in the address phase so data leaves a flip-flop
	always_comb begin
		rdata_d = 32'h0000_0000;
		case (haddr[7:0])
			OFS_FEATURE: rdata_d = {24'h000000, feature_q};
			OFS_SECT_COUNT: rdata_d = {24'h000000, sect_count_q};
			OFS_SECT_NUM: rdata_d = {24'h000000, sect_num_q};
			OFS_CYL_LOW: rdata_d = {24'h000000, cyl_low_q};
			OFS_CYL_HIGH: rdata_d = {24'h000000, cyl_high_q};
			OFS_DEV_HEAD: rdata_d = {24'h000000, dev_head_q};
			OFS_COMMAND: rdata_d = {24'h000000, command_q};
			OFS_ERROR: rdata_d = {24'h000000, error_q};
			OFS_STATUS: rdata_d = {24'h000000, status};
			OFS_FEAT_STATE: rdata_d = {16'h0000, feat_state};
			OFS_APM_LEVEL: rdata_d = {24'h000000, apm_level_q};
			OFS_XFER_MODE: rdata_d = {24'h000000, xfer_q};
			OFS_HOST_TIME: rdata_d = host_time_q;
			default: rdata_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			rdata_q <= 32'h0000_0000;
		end else begin
			wr_pend_q <= addr_phase && hwrite;
			if (addr_phase) begin
				wr_addr_q <= haddr[7:0];
			end
			if (addr_phase && !hwrite) begin
				rdata_q <= rdata_d;
			end
		end
	end

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (cmd_write && wr_addr_q == OFS_COMMAND) begin
					state_d = ST_EXEC;
				end
			end
			ST_EXEC: begin
				// no format check gates the seek path
				state_d = is_seek(command_q) ? ST_SEEK : ST_IDLE;
			end
			ST_SEEK: begin
				if (seek_done) begin
					state_d = ST_IDLE;
				end
			end
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// taskfile: host writes when idle, position written back at seek end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			feature_q <= 8'h00;
			sect_count_q <= 8'h00;
			sect_num_q <= 8'h00;
			cyl_low_q <= 8'h00;
			cyl_high_q <= 8'h00;
			dev_head_q <= 8'h00;
			command_q <= 8'h00;
		end else if (cmd_write) begin
			case (wr_addr_q)
				OFS_FEATURE: feature_q <= hwdata[7:0];
				OFS_SECT_COUNT: sect_count_q <= hwdata[7:0];
				OFS_SECT_NUM: sect_num_q <= hwdata[7:0];
				OFS_CYL_LOW: cyl_low_q <= hwdata[7:0];
				OFS_CYL_HIGH: cyl_high_q <= hwdata[7:0];
				OFS_DEV_HEAD: dev_head_q <= hwdata[7:0];
				OFS_COMMAND: command_q <= hwdata[7:0];
				default: ;
			endcase
		end else if (state_q == ST_SEEK && seek_done) begin
			// the actuator sits on the target, so current position equals it
			sect_num_q <= seek_target[7:0];
			cyl_low_q <= seek_target[15:8];
			cyl_high_q <= seek_target[23:16];
			dev_head_q <= {dev_head_q[7:4], seek_target[27:24]};
		end
	end

	// error flags cleared when a new command starts; seek-complete cleared only when that command is a seek
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			error_q <= 8'h00;
			seek_end_q <= 1'b1;
		end else if (state_q == ST_IDLE && state_d == ST_EXEC) begin
			error_q <= 8'h00;
			if (is_seek(hwdata[7:0])) begin
				seek_end_q <= 1'b0;
			end
		end else if (state_q == ST_EXEC) begin
			if (sf_exec && sf_abort) begin
				error_q[ERR_ABORT_BIT] <= 1'b1;
			end else if (!is_seek(command_q) && command_q != CMD_SET_FEATURES) begin
				error_q[ERR_ABORT_BIT] <= 1'b1;
			end
		end else if (state_q == ST_SEEK && seek_done) begin
			seek_end_q <= 1'b1;
		end
	end

	// seek request to the servo, held until it reports arrival
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			seek_req <= 1'b0;
			seek_lba <= 1'b0;
			seek_target <= 28'h0000000;
		end else if (state_q == ST_EXEC && is_seek(command_q)) begin
			seek_req <= 1'b1;
			seek_lba <= dev_head_q[DH_LBA_BIT];
			// both modes share one layout: cylinder in 23:8, head in 27:24
			seek_target <= {dev_head_q[3:0], cyl_high_q, cyl_low_q, sect_num_q};
		end else if (seek_done) begin
			seek_req <= 1'b0;
		end
	end

	// feature state; only a hard reset restores the defaults
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wc_q <= RST_WRITE_CACHE;
			rla_q <= RST_READ_AHEAD;
			revert_q <= RST_REVERT;
			apm_q <= 1'b0;
			apm_level_q <= 8'h00;
			puis_q <= 1'b0;
			spinup_q <= 1'b0;
			serial_q <= 6'h00;
			xfer_q <= RST_XFER_MODE;
			host_time_q <= 32'h0000_0000;
		end else begin
			if (reassign_full) begin
				wc_q <= 1'b0;
			end else if (sf_exec && feature_q == SF_WC_ON) begin
				wc_q <= 1'b1;
			end else if (sf_exec && feature_q == SF_WC_OFF) begin
				wc_q <= 1'b0;
			end
			if (sf_exec) begin
				case (feature_q)
					SF_RLA_ON: rla_q <= 1'b1;
					SF_RLA_OFF: rla_q <= 1'b0;
					SF_REVERT_ON: revert_q <= 1'b1;
					SF_REVERT_OFF: revert_q <= 1'b0;
					SF_APM_ON: begin
						if (!sf_abort) begin
							apm_q <= 1'b1;
							apm_level_q <= sect_count_q;
						end
					end
					SF_APM_OFF: apm_q <= 1'b0;
					SF_PUIS_ON: puis_q <= 1'b1;
					SF_PUIS_OFF: puis_q <= 1'b0;
					SF_PUIS_SPINUP: spinup_q <= 1'b1;
					SF_SERIAL_ON: begin
						if (!sf_abort) begin
							serial_q[sect_count_q[2:0] - 3'h1] <= 1'b1;
						end
					end
					SF_SERIAL_OFF: begin
						if (!sf_abort) begin
							serial_q[sect_count_q[2:0] - 3'h1] <= 1'b0;
						end
					end
					SF_XFER_MODE: begin
						if (!sf_abort) begin
							xfer_q <= sect_count_q;
						end
					end
					SF_HOST_TIME: begin
						host_time_q <= {cyl_high_q, cyl_low_q, sect_num_q, sect_count_q};
					end
					default: ;
				endcase
			end
		end
	end

	assign write_cache_on = wc_q;
	assign read_ahead_on = rla_q;

endmodule : seek_feat_cmd

// *** dv/seek_feat_monitor.sv ***
`timescale 1ns/1ns
module seek_feat_monitor
	import seek_feat_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic reassign_full,
	input wire logic seek_done,
	input wire logic seek_req,
	input wire logic seek_lba,
	input wire logic [27:0] seek_target,
	input wire logic write_cache_on,
	input wire logic read_ahead_on
);
	default clocking dc @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	logic cmd_q;
	logic seek_go;
	// command code rides on hwdata one cycle after its address phase
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cmd_q <= 1'b0;
		end else if (hready) begin
			cmd_q <= hsel && htrans[1] && hwrite && haddr[7:0] == OFS_COMMAND;
		end
	end
	assign seek_go = cmd_q && hwdata[7:4] == CMD_SEEK_NIBBLE;
	a_reset_feat: assert property (disable iff (1'b0)
		!rst_n |-> write_cache_on && read_ahead_on) else $error("defaults lost in reset");
	a_full_cache: assert property (reassign_full |=> !write_cache_on)
		else $error("cache on while reassign full");
	a_seek_start: assert property (seek_go |-> ##2 seek_req)
		else $error("seek command did not start seek");
	a_seek_cause: assert property ($rose(seek_req) |-> $past(seek_go, 2))
		else $error("seek without command");
	a_seek_end: assert property (seek_req && seek_done |=> !seek_req)
		else $error("seek not ended");
	a_seek_hold: assert property (seek_req && !seek_done |=> seek_req)
		else $error("seek dropped early");
	a_target_hold: assert property (seek_req && $past(seek_req) |->
		$stable({seek_target, seek_lba})) else $error("target moved in seek");
	a_cache_cause: assert property ($changed(write_cache_on) |->
		$past(cmd_q, 2) || $past(cmd_q, 3) || $past(reassign_full)) else $error("cache flip");
	a_ahead_cause: assert property ($changed(read_ahead_on) |->
		$past(cmd_q, 2) || $past(cmd_q, 3)) else $error("look-ahead flip");
	c_seek: cover property (seek_req && seek_done);
	c_full: cover property (reassign_full && cmd_q);
	c_ahead: cover property ($fell(read_ahead_on));
endmodule : seek_feat_monitor
bind seek_feat_cmd seek_feat_monitor i_mon (.clock, .rst_n, .hsel, .haddr, .htrans, .hwrite,
	.hwdata, .hready, .reassign_full, .seek_done, .seek_req, .seek_lba, .seek_target,
	.write_cache_on, .read_ahead_on);

// *** dv/servo_model.sv ***
`timescale 1ns/1ns
module servo_model (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic seek_req,
	input wire logic slow,
	output logic seek_done
);
	logic [3:0] cnt_q;
	// never answers in the start cycle; slow mode stands for a long arm move
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 4'h0;
			seek_done <= 1'b0;
		end else begin
			seek_done <= 1'b0;
			if (!seek_req) begin
				cnt_q <= 4'h0;
			end else if (!seek_done) begin
				cnt_q <= cnt_q + 4'h1;
				seek_done <= cnt_q == (slow ? 4'h9 : 4'h1);
			end
		end
	end
endmodule : servo_model

// *** dv/seek_feat_cmd_bench.sv ***
`timescale 1ns/1ns
module seek_feat_cmd_bench;
	import seek_feat_pkg::*;
	logic clock = 1'b0, rst_n = 1'b1, hsel = 1'b0, hwrite = 1'b0, reassign_full = 1'b0;
	logic slow = 1'b0, rd_ph = 1'b0, ok;
	logic [31:0] haddr = '0, hwdata = '0, hrdata;
	logic [1:0] htrans = 2'h0;
	logic hreadyout, hresp, seek_done, seek_req, seek_lba, write_cache_on, read_ahead_on;
	logic [27:0] seek_target;
	logic [7:0] xm, sc, feat;
	logic [31:0] exp_q[$];
	logic [4:0] tt [4] = '{5'h00, 5'h01, 5'h04, 5'h08};
	logic [16:0] ta [15] = '{17'h08200, 17'h05500, 17'h0cc00, 17'h00580, 17'h00600,
		17'h00700, 17'h01002, 17'h04311, 17'h04a00, 17'h10500, 17'h105ff, 17'h11005,
		17'h11007, 17'h11100, 17'h10000};
	logic [16:0] tb [6] = '{17'h00200, 17'h0aa00, 17'h06600, 17'h08500, 17'h08600, 17'h09002};
	int n_mismatch = 0, num_checks = 0, seed = 32'h0e940827;
	seek_feat_cmd i_dut (.clock, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .reassign_full,
		.seek_done, .seek_req, .seek_lba, .seek_target, .write_cache_on, .read_ahead_on);
	servo_model i_servo (.clock, .rst_n, .seek_req, .slow, .seek_done);
	initial forever #4 clock = ~clock;
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : test_done
	// r picks the bus ready, else the seek request; a stuck wait ends the run
	task automatic hold(input bit r, input logic v);
		int n;
		n = 0;
		while ((r ? hreadyout : seek_req) !== v) begin
			n++;
			if (n > 64) begin
				n_mismatch++;
				test_done;
			end
			@(posedge clock);
		end
	endtask : hold
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		@(posedge clock);
		hold(1'b1, 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clock);
		hold(1'b1, 1'b1);
	endtask : xfer
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		xfer(a, 1'b0, '0);
	endtask : rd
	always @(posedge clock) begin
		if (rd_ph) check("hrdata", hrdata, exp_q.pop_front());
		rd_ph <= hsel && htrans[1] && !hwrite && hreadyout;
	end
	task automatic sf(input logic [7:0] f, input logic [7:0] c, input logic ab);
		feat = f;
		xfer(OFS_FEATURE, 1'b1, {24'h0, f});
		xfer(OFS_SECT_COUNT, 1'b1, {24'h0, c});
		xfer(OFS_COMMAND, 1'b1, {24'h0, CMD_SET_FEATURES});
		repeat (3) @(posedge clock);
		rd(OFS_ERROR, {29'h0, ab, 2'h0});
	endtask : sf
	task automatic seek(input logic [7:0] s, lo, hi, dh, cmd, input logic sl);
		slow <= sl;
		xfer(OFS_SECT_NUM, 1'b1, {24'h0, s});
		xfer(OFS_CYL_LOW, 1'b1, {24'h0, lo});
		xfer(OFS_CYL_HIGH, 1'b1, {24'h0, hi});
		xfer(OFS_DEV_HEAD, 1'b1, {24'h0, dh});
		xfer(OFS_COMMAND, 1'b1, {24'h0, cmd});
		hold(1'b0, 1'b1);
		check("seek_lba", seek_lba, dh[6]);
		check("seek_target", seek_target, {dh[3:0], hi, lo, s});
		// only the slow seek is long enough to hit the busy window
		if (sl) begin
			xfer(OFS_FEATURE, 1'b1, 32'h99);
			rd(OFS_STATUS, 32'h80);
		end
		hold(1'b0, 1'b0);
		repeat (2) @(posedge clock);
		rd(OFS_ERROR, '0);
		rd(OFS_STATUS, 32'h50);
		rd(OFS_SECT_NUM, {24'h0, s});
		rd(OFS_CYL_LOW, {24'h0, lo});
		rd(OFS_CYL_HIGH, {24'h0, hi});
		rd(OFS_DEV_HEAD, {24'h0, dh});
		rd(OFS_FEATURE, {24'h0, feat});
	endtask : seek
	function automatic logic legal(input logic [7:0] v);
		case (v[7:3])
			5'h00: return v[2:0] <= 3'h1;
			5'h01: return v[2:0] <= 3'h4;
			5'h04: return v[2:0] <= 3'h2;
			5'h08: return v[2:0] <= 3'h6;
			default: return 1'b0;
		endcase
	endfunction : legal
	initial begin
		// a real falling edge at time zero puts every flop into reset before the first clock
		rst_n <= 1'b0;
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		check("write_cache_on", write_cache_on, 1'b1);
		check("read_ahead_on", read_ahead_on, 1'b1);
		rd(OFS_FEAT_STATE, 32'h3);
		rd(OFS_XFER_MODE, '0);
		rd(8'h3c, '0);
		foreach (ta[i]) sf(ta[i][15:8], ta[i][7:0], ta[i][16]);
		check("write_cache_on", write_cache_on, 1'b0);
		check("read_ahead_on", read_ahead_on, 1'b0);
		rd(OFS_FEAT_STATE, 32'h23c);
		foreach (tb[i]) sf(tb[i][15:8], tb[i][7:0], tb[i][16]);
		check("write_cache_on", write_cache_on, 1'b1);
		check("read_ahead_on", read_ahead_on, 1'b1);
		rd(OFS_FEAT_STATE, 32'h23);
		rd(OFS_APM_LEVEL, 32'h80);
		rd(OFS_HOST_TIME, 32'h11);
		xfer(OFS_COMMAND, 1'b1, 32'h20);
		repeat (3) @(posedge clock);
		rd(OFS_ERROR, 32'h4);
		rd(OFS_STATUS, 32'h51);
		xm = 8'h00;
		for (int k = 0; k < 48; k++) begin
			sc = (k < 32) ? {tt[k / 8], k[2:0]} : 8'($random(seed));
			ok = legal(sc);
			sf(SF_XFER_MODE, sc, !ok);
			xm = ok ? sc : xm;
			rd(OFS_XFER_MODE, {24'h0, xm});
		end
		seek(8'h5a, 8'h34, 8'h12, 8'ha3, 8'h70, 1'b1);
		seek(8'hc3, 8'h9e, 8'h4d, 8'he7, 8'h7f, 1'b0);
		reassign_full <= 1'b1;
		sf(SF_WC_ON, 8'h00, 1'b0);
		check("write_cache_on", write_cache_on, 1'b0);
		rst_n <= 1'b0;
		reassign_full <= 1'b0;
		repeat (3) @(posedge clock);
		check("write_cache_on", write_cache_on, 1'b1);
		check("read_ahead_on", read_ahead_on, 1'b1);
		rst_n <= 1'b1;
		@(posedge clock);
		rd(OFS_XFER_MODE, '0);
		test_done;
	end
endmodule : seek_feat_cmd_bench
